// file: core/tog_regs.svh
// Register map, field positions, reset values and timing counts.
// Operation
// - Heartbeat divides 1 MHz by both divisors.
// - Each divisor is 16 bits, 2 to 65535.
// - Divisor 0 or 1 holds heartbeat high.
// - Synchronous mode below 1 Hz holds heartbeat high.
// - Synchronous heartbeat realigns at each 1 PPS.
// - Heartbeat or synthesizer drives the shared pin.
// - Synthesizer frequency is tuning word over 32.
// - Continuous mode realigns synthesizer every second.
// - Fractional aligns once; new word realigns again.
// - Divider source: raw, multiplied or 100 MHz.
// - Decade mode divides by ten^0 to ten^7.
// - Period mode half period is value plus two.
// - Multiplier factors 1,2,3,4,6,8,10,16.
// - Synthesizer output edges can raise interrupts.
// - Power-on restores stored synthesizer settings.
// - Strobe pulse lasts exactly one microsecond.
// - Strobe mode 0 full time, 1 subsecond.
// - Seven interrupt sources, each with mask bit.
// - Firing source sets its flag bit.
// - Flag bits map to the seven fixed sources.
// - 1 PPS output is 60 us pulse.
// - Fixed output selects 1, 5 or 10 MHz.
`ifndef TOG_REGS_SVH
`define TOG_REGS_SVH

`define TOG_OFS_DIVISORS 8'h00
`define TOG_OFS_TUNING 8'h04
`define TOG_OFS_PERIOD 8'h08
`define TOG_OFS_STB_MINOR 8'h0c
`define TOG_OFS_CONTROL 8'h10
`define TOG_OFS_STB_MAJOR 8'h14
`define TOG_OFS_MASK 8'h18
`define TOG_OFS_FLAGS 8'h1c

`define TOG_CTL_HB_SYNC 0
`define TOG_CTL_OUT_SEL 1
`define TOG_CTL_DDS_CONT 2
`define TOG_CTL_DIV_SRC 3
`define TOG_CTL_PERIOD 5
`define TOG_CTL_DECADE 6
`define TOG_CTL_MULT 9
`define TOG_CTL_STB_MODE 12
`define TOG_CTL_EDGE_POL 13
`define TOG_CTL_FSEL 14
`define TOG_CTL_DDS_MASK 32'h0000_0ffc

`define TOG_RST_DIVISORS 32'h0002_0002
`define TOG_RST_CONTROL 32'h0000_0000
`define TOG_RST_MASK 32'h0000_0000

`define TOG_CLK_MHZ 100
`define TOG_TICK_CYC (`TOG_CLK_MHZ)
`define TOG_HB_MAX_PROD 1000000
`define TOG_DDS_MOD (37'd32 * 37'd100000000)
`define TOG_STB_NS 1000
`define TOG_STB_CYC (`TOG_STB_NS * `TOG_CLK_MHZ / 1000)
`define TOG_PPS_US 60
`define TOG_PPS_CYC (`TOG_PPS_US * `TOG_CLK_MHZ)
`define TOG_F1_HALF (`TOG_CLK_MHZ / 2)
`define TOG_F5_HALF (`TOG_CLK_MHZ / 10)
`define TOG_F10_HALF (`TOG_CLK_MHZ / 20)

`endif

// file: core/tog_pkg.sv
// Types shared by the timing output generator.
package tog_pkg;
  typedef enum logic [1:0] {
    TOG_SRC_RAW = 2'b00,
    TOG_SRC_MULT = 2'b01,
    TOG_SRC_PLL = 2'b10,
    TOG_SRC_RSVD = 2'b11
  } tog_src_t;

  typedef enum logic [1:0] {
    TOG_F_1MHZ = 2'b00,
    TOG_F_5MHZ = 2'b01,
    TOG_F_10MHZ = 2'b10,
    TOG_F_RSVD = 2'b11
  } tog_fsel_t;

  typedef logic [36:0] tog_phase_t;
endpackage

// file: core/tog_dds_if.sv
// Carrier between the controller and one phase accumulator.
`timescale 1ns/10ps
`default_nettype none
interface tog_dds_if;
  import tog_pkg::*;
  tog_phase_t step;
  logic clear;
  logic wave;
  logic rise;
  modport acc (input step, input clear, output wave, output rise);
  modport ctl (output step, output clear, input wave, input rise);
endinterface
`default_nettype wire

// file: core/tog_dds_acc.sv
// Modulo phase accumulator producing a square wave.
`timescale 1ns/10ps
`default_nettype none
`include "tog_regs.svh"
module tog_dds_acc
  import tog_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  tog_dds_if.acc dds
);
  tog_phase_t acc_q;
  tog_phase_t acc_d;
  tog_phase_t sum;
  logic wave_q;
  logic wave_d;

  assign sum = acc_q + dds.step;
  assign acc_d = dds.clear ? '0 :
                 (sum >= `TOG_DDS_MOD) ? sum - `TOG_DDS_MOD : sum;
  assign wave_d = acc_d < (`TOG_DDS_MOD >> 1);
  assign dds.wave = wave_q;
  assign dds.rise = wave_d & ~wave_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_q <= '0;
      wave_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      wave_q <= wave_d;
    end
  end
endmodule // tog_dds_acc
`default_nettype wire

// file: core/tog_top.sv
// Timing output generator: heartbeat, synthesizer, strobe, interrupts.
`timescale 1ns/10ps
`default_nettype none
`include "tog_regs.svh"
module tog_top
  import tog_pkg::*;
#(
  parameter int unsigned PPS_CYCLES = `TOG_PPS_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [31:0] nv_tuning_i,
  input wire logic [31:0] nv_period_i,
  input wire logic [31:0] nv_control_i,
  input wire logic pps_i,
  input wire logic [31:0] major_time_i,
  input wire logic [19:0] minor_time_i,
  input wire logic event_i,
  input wire logic event2_i,
  input wire logic event3_i,
  input wire logic rx_packet_i,
  output logic shared_out_o,
  output logic strobe_o,
  output logic pps_o,
  output logic freq_o,
  output logic irq_o
);
  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0] divisors_q;
  logic [31:0] tuning_q;
  logic [31:0] period_q;
  logic [19:0] stb_minor_q;
  logic [31:0] stb_major_q;
  logic [31:0] control_q;
  logic [6:0] mask_q;
  logic [6:0] flags_q;
  logic [6:0] flags_d;
  logic [6:0] int_evt;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic restore_q;
  logic wr_div;
  logic wr_tun;
  logic wr_per;
  logic wr_smin;
  logic wr_ctl;
  logic wr_smaj;
  logic wr_mask;
  logic wr_flag;

  assign wr_div = reg_wr_i & (reg_addr_i == `TOG_OFS_DIVISORS);
  assign wr_tun = reg_wr_i & (reg_addr_i == `TOG_OFS_TUNING);
  assign wr_per = reg_wr_i & (reg_addr_i == `TOG_OFS_PERIOD);
  assign wr_smin = reg_wr_i & (reg_addr_i == `TOG_OFS_STB_MINOR);
  assign wr_ctl = reg_wr_i & (reg_addr_i == `TOG_OFS_CONTROL);
  assign wr_smaj = reg_wr_i & (reg_addr_i == `TOG_OFS_STB_MAJOR);
  assign wr_mask = reg_wr_i & (reg_addr_i == `TOG_OFS_MASK);
  assign wr_flag = reg_wr_i & (reg_addr_i == `TOG_OFS_FLAGS);

  always_comb begin
    unique case (reg_addr_i)
      `TOG_OFS_DIVISORS: rdata_d = divisors_q;
      `TOG_OFS_TUNING: rdata_d = tuning_q;
      `TOG_OFS_PERIOD: rdata_d = period_q;
      `TOG_OFS_STB_MINOR: rdata_d = {12'h000, stb_minor_q};
      `TOG_OFS_CONTROL: rdata_d = control_q;
      `TOG_OFS_STB_MAJOR: rdata_d = stb_major_q;
      `TOG_OFS_MASK: rdata_d = {25'h0000000, mask_q};
      `TOG_OFS_FLAGS: rdata_d = {25'h0000000, flags_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Software clears flags by writing ones; a new event wins the clear.
  assign flags_d = (flags_q & ~({7{wr_flag}} & reg_wdata_i[6:0]))
                   | int_evt;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      restore_q <= 1'b1;
      divisors_q <= `TOG_RST_DIVISORS;
      tuning_q <= 32'h0000_0000;
      period_q <= 32'h0000_0000;
      stb_minor_q <= 20'h00000;
      stb_major_q <= 32'h0000_0000;
      control_q <= `TOG_RST_CONTROL;
      mask_q <= 7'h00;
      flags_q <= 7'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      restore_q <= 1'b0;
      if (restore_q) begin
        tuning_q <= nv_tuning_i;
        period_q <= nv_period_i;
        control_q <= nv_control_i & `TOG_CTL_DDS_MASK;
      end else begin
        if (wr_tun) tuning_q <= reg_wdata_i;
        if (wr_per) period_q <= reg_wdata_i;
        if (wr_ctl) control_q <= reg_wdata_i;
      end
      if (wr_div) divisors_q <= reg_wdata_i;
      if (wr_smin) stb_minor_q <= reg_wdata_i[19:0];
      if (wr_smaj) stb_major_q <= reg_wdata_i;
      if (wr_mask) mask_q <= reg_wdata_i[6:0];
      flags_q <= flags_d;
      if (reg_rd_i) rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  logic hb_sync;
  logic out_sel;
  logic dds_cont;
  tog_src_t div_src;
  logic period_mode;
  logic [2:0] decade;
  logic [2:0] mult_sel;
  logic stb_mode;
  logic edge_pol;
  tog_fsel_t fsel;
  logic [15:0] first_divisor;
  logic [15:0] second_divisor;

  assign hb_sync = control_q[`TOG_CTL_HB_SYNC];
  assign out_sel = control_q[`TOG_CTL_OUT_SEL];
  assign dds_cont = control_q[`TOG_CTL_DDS_CONT];
  assign div_src = tog_src_t'(control_q[`TOG_CTL_DIV_SRC +: 2]);
  assign period_mode = control_q[`TOG_CTL_PERIOD];
  assign decade = control_q[`TOG_CTL_DECADE +: 3];
  assign mult_sel = control_q[`TOG_CTL_MULT +: 3];
  assign stb_mode = control_q[`TOG_CTL_STB_MODE];
  assign edge_pol = control_q[`TOG_CTL_EDGE_POL];
  assign fsel = tog_fsel_t'(control_q[`TOG_CTL_FSEL +: 2]);
  assign first_divisor = divisors_q[15:0];
  assign second_divisor = divisors_q[31:16];

  // ----------------------------------------------------------------
  // Heartbeat divider
  // ----------------------------------------------------------------
  logic [6:0] us_cnt_q;
  logic us_tick;
  logic [15:0] c1_q;
  logic [15:0] c2_q;
  logic c1_wrap;
  logic [31:0] hb_prod;
  logic hb_force;
  logic hb_realign;
  logic hb_q;

  assign hb_realign = hb_sync & pps_i;
  assign us_tick = us_cnt_q == 7'(`TOG_TICK_CYC - 1);
  assign c1_wrap = us_tick & (c1_q == first_divisor - 16'h0001);
  assign hb_prod = first_divisor * second_divisor;
  assign hb_force = (first_divisor < 16'h0002)
                    | (second_divisor < 16'h0002)
                    | (hb_sync & (hb_prod > `TOG_HB_MAX_PROD));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      us_cnt_q <= 7'h00;
      c1_q <= 16'h0000;
      c2_q <= 16'h0000;
      hb_q <= 1'b1;
    end else begin
      if (hb_realign | us_tick) us_cnt_q <= 7'h00;
      else us_cnt_q <= us_cnt_q + 7'h01;
      if (hb_realign | c1_wrap) c1_q <= 16'h0000;
      else if (us_tick) c1_q <= c1_q + 16'h0001;
      if (hb_realign) begin
        c2_q <= 16'h0000;
      end else if (c1_wrap) begin
        if (c2_q == second_divisor - 16'h0001) c2_q <= 16'h0000;
        else c2_q <= c2_q + 16'h0001;
      end
      hb_q <= hb_force | (c2_q < (second_divisor >> 1));
    end
  end

  // ----------------------------------------------------------------
  // Synthesizer and multiplier
  // ----------------------------------------------------------------
  function automatic logic [4:0] mult_factor(input logic [2:0] sel);
    logic [4:0] f;
    f = 5'd1;
    unique case (sel)
      3'd0: f = 5'd1;
      3'd1: f = 5'd2;
      3'd2: f = 5'd3;
      3'd3: f = 5'd4;
      3'd4: f = 5'd6;
      3'd5: f = 5'd8;
      3'd6: f = 5'd10;
      3'd7: f = 5'd16;
    endcase
    return f;
  endfunction

  tog_dds_if raw_if ();
  tog_dds_if mul_if ();
  logic resync_q;
  logic dds_align;

  // Fractional mode aligns only when a new word or mode is pending.
  assign dds_align = pps_i & (dds_cont | resync_q);
  assign raw_if.step = tog_phase_t'(tuning_q);
  assign mul_if.step = tog_phase_t'(tuning_q)
                       * tog_phase_t'(mult_factor(mult_sel));
  assign raw_if.clear = dds_align;
  assign mul_if.clear = dds_align;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      resync_q <= 1'b1;
    end else if (wr_tun | wr_ctl | restore_q) begin
      resync_q <= 1'b1;
    end else if (pps_i) begin
      resync_q <= 1'b0;
    end
  end

  tog_dds_acc u_raw (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .dds(raw_if)
  );

  tog_dds_acc u_mul (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .dds(mul_if)
  );

  // ----------------------------------------------------------------
  // Output divider
  // ----------------------------------------------------------------
  function automatic logic [31:0] pow10(input logic [2:0] e);
    logic [31:0] v;
    v = 32'd1;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(e)) v = v * 32'd10;
    end
    return v;
  endfunction

  logic pll_q;
  logic src_lvl;
  logic src_rise;
  logic [31:0] div_lim;
  logic [31:0] div_cnt_q;
  logic per_q;
  logic div_lvl;
  logic dds_out;

  assign src_lvl = (div_src == TOG_SRC_RAW) ? raw_if.wave :
                   (div_src == TOG_SRC_MULT) ? mul_if.wave : pll_q;
  assign src_rise = (div_src == TOG_SRC_RAW) ? raw_if.rise :
                    (div_src == TOG_SRC_MULT) ? mul_if.rise : 1'b1;
  assign div_lim = pow10(decade);
  assign div_lvl = (decade == 3'd0) ? src_lvl :
                   (div_cnt_q < (div_lim >> 1));
  assign dds_out = period_mode ? per_q : div_lvl;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pll_q <= 1'b0;
      div_cnt_q <= 32'h0000_0000;
      per_q <= 1'b0;
    end else begin
      pll_q <= ~pll_q;
      if (dds_align) begin
        div_cnt_q <= 32'h0000_0000;
        per_q <= 1'b0;
      end else if (src_rise) begin
        if (period_mode) begin
          if (div_cnt_q >= period_q + 32'd1) begin
            div_cnt_q <= 32'h0000_0000;
            per_q <= ~per_q;
          end else begin
            div_cnt_q <= div_cnt_q + 32'd1;
          end
        end else if (div_cnt_q >= div_lim - 32'd1) begin
          div_cnt_q <= 32'h0000_0000;
        end else begin
          div_cnt_q <= div_cnt_q + 32'd1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared output pin
  // ----------------------------------------------------------------
  logic shared_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) shared_q <= 1'b1;
    else shared_q <= out_sel ? dds_out : hb_q;
  end

  assign shared_out_o = shared_q;

  // ----------------------------------------------------------------
  // Coincidence strobe
  // ----------------------------------------------------------------
  logic stb_hit;
  logic stb_hit_q;
  logic [6:0] stb_cnt_q;
  logic strobe_q;

  assign stb_hit = (minor_time_i == stb_minor_q)
                   & (stb_mode | (major_time_i == stb_major_q));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stb_hit_q <= 1'b0;
      stb_cnt_q <= 7'h00;
      strobe_q <= 1'b0;
    end else begin
      stb_hit_q <= stb_hit;
      if (stb_hit & ~stb_hit_q) begin
        stb_cnt_q <= 7'(`TOG_STB_CYC - 1);
        strobe_q <= 1'b1;
      end else if (stb_cnt_q != 7'h00) begin
        stb_cnt_q <= stb_cnt_q - 7'h01;
      end else begin
        strobe_q <= 1'b0;
      end
    end
  end

  assign strobe_o = strobe_q;

  // ----------------------------------------------------------------
  // 1 PPS output and fixed frequency
  // ----------------------------------------------------------------
  logic [12:0] pps_cnt_q;
  logic pps_q;
  logic [6:0] f_cnt_q;
  logic [6:0] f_half;
  logic freq_q;

  assign f_half = (fsel == TOG_F_5MHZ) ? 7'(`TOG_F5_HALF) :
                  (fsel == TOG_F_10MHZ) ? 7'(`TOG_F10_HALF) :
                  7'(`TOG_F1_HALF);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pps_cnt_q <= 13'h0000;
      pps_q <= 1'b0;
      f_cnt_q <= 7'h00;
      freq_q <= 1'b0;
    end else begin
      if (pps_i) begin
        pps_cnt_q <= 13'(PPS_CYCLES - 1);
        pps_q <= 1'b1;
      end else if (pps_cnt_q != 13'h0000) begin
        pps_cnt_q <= pps_cnt_q - 13'h0001;
      end else begin
        pps_q <= 1'b0;
      end
      if (f_cnt_q >= f_half - 7'h01) begin
        f_cnt_q <= 7'h00;
        freq_q <= ~freq_q;
      end else begin
        f_cnt_q <= f_cnt_q + 7'h01;
      end
    end
  end

  assign pps_o = pps_q;
  assign freq_o = freq_q;

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  logic ev_q;
  logic ev2_q;
  logic ev3_q;
  logic out_prev_q;
  logic stb_prev_q;
  logic pps_prev_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ev_q <= 1'b0;
      ev2_q <= 1'b0;
      ev3_q <= 1'b0;
      out_prev_q <= 1'b1;
      stb_prev_q <= 1'b0;
      pps_prev_q <= 1'b0;
    end else begin
      ev_q <= event_i;
      ev2_q <= event2_i;
      ev3_q <= event3_i;
      out_prev_q <= shared_q;
      stb_prev_q <= strobe_q;
      pps_prev_q <= pps_q;
    end
  end

  // Edge polarity high picks falling edges on sources 0 and 1.
  assign int_evt[0] = edge_pol ? (ev_q & ~event_i)
                               : (~ev_q & event_i);
  assign int_evt[1] = edge_pol ? (out_prev_q & ~shared_q)
                               : (~out_prev_q & shared_q);
  assign int_evt[2] = strobe_q & ~stb_prev_q;
  assign int_evt[3] = pps_q & ~pps_prev_q;
  assign int_evt[4] = rx_packet_i;
  assign int_evt[5] = ev2_q ^ event2_i;
  assign int_evt[6] = ev3_q ^ event3_i;

  assign irq_o = |(flags_q & mask_q);
endmodule // tog_top
`default_nettype wire

// file: verif/tog_props.sv
// Concurrent checks on the timing output generator ports.
`timescale 1ns/10ps
`default_nettype none
`include "tog_regs.svh"
module tog_props #(
  parameter int unsigned PPS_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic pps_i,
  input wire logic strobe_o,
  input wire logic pps_o
);
  // ------------------------------------------------------------
  // Pulse length counters.
  // ------------------------------------------------------------
  logic [31:0] pps_cnt_q;
  logic [31:0] stb_cnt_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pps_cnt_q <= 32'h0;
      stb_cnt_q <= 32'h0;
    end else begin
      pps_cnt_q <= pps_o ? pps_cnt_q + 32'h1 : 32'h0;
      stb_cnt_q <= strobe_o ? stb_cnt_q + 32'h1 : 32'h0;
    end
  end
  // ------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence wr_at(logic [7:0] a);
    reg_wr_i && reg_addr_i == a;
  endsequence
  sequence rd_at(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  pps_start_a: assert property (pps_i |=> pps_o)
    else $error("pps output did not follow epoch");
  pps_width_a: assert property (
    $fell(pps_o) |-> pps_cnt_q == PPS_CYCLES)
    else $error("pps output width wrong");
  strobe_width_a: assert property (
    $fell(strobe_o) |-> stb_cnt_q == `TOG_STB_CYC)
    else $error("strobe width wrong");
  unmapped_read_a: assert property (
    rd_at(8'h20) |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
  mask_rw_a: assert property (
    wr_at(`TOG_OFS_MASK) ##1 rd_at(`TOG_OFS_MASK)
    |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 32'h7f))
    else $error("mask readback wrong");
  tuning_rw_a: assert property (
    wr_at(`TOG_OFS_TUNING) ##1 rd_at(`TOG_OFS_TUNING)
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("tuning readback wrong");
  flags_rsvd_a: assert property (
    rd_at(`TOG_OFS_FLAGS) |=> reg_rdata_o[31:7] == 25'h0)
    else $error("flag reserved bits set");
endmodule // tog_props
bind tog_top tog_props #(.PPS_CYCLES(PPS_CYCLES)) u_props (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o),
  .pps_i(pps_i),
  .strobe_o(strobe_o),
  .pps_o(pps_o)
);
`default_nettype wire

// file: verif/tog_sink.sv
// Equipment model that measures high and low run lengths of one output.
`timescale 1ns/10ps
`default_nettype none
module tog_sink (
  input wire logic clk_i,
  input wire logic sig_i,
  output var logic [31:0] hi_len_o,
  output var logic [31:0] lo_len_o
);
  // ------------------------------------------------------------
  // Run length capture.
  // ------------------------------------------------------------
  logic lvl_q = 1'b0;
  logic [31:0] run_q = 32'h0;
  logic [31:0] hi_q = 32'h0;
  logic [31:0] lo_q = 32'h0;
  assign hi_len_o = hi_q;
  assign lo_len_o = lo_q;
  always @(posedge clk_i) begin
    if (sig_i === lvl_q) begin
      run_q <= run_q + 32'h1;
    end else begin
      if (lvl_q) begin
        hi_q <= run_q;
      end else begin
        lo_q <= run_q;
      end
      lvl_q <= sig_i;
      run_q <= 32'h1;
    end
  end
endmodule // tog_sink
`default_nettype wire

// file: verif/tog_top_tb_top.sv
// Self-checking testbench of the timing output generator.
`timescale 1ns/10ps
`default_nettype none
`include "tog_regs.svh"
`define CHK(g, e) check_val(g, e)
module tog_top_tb_top;
  import tog_pkg::*;
  // ------------------------------------------------------------
  // Signals, design and equipment models.
  // ------------------------------------------------------------
  localparam int unsigned PPS_N = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic pps = 1'b0;
  logic [19:0] minor = 20'h0;
  logic [31:0] major = 32'h0;
  logic ev = 1'b0, ev2 = 1'b0, ev3 = 1'b0, rx = 1'b0;
  logic shared, strobe, ppso, freq, irq;
  logic [31:0] hb_hi, hb_lo, fq_hi, pp_hi, st_hi, d;
  int fails = 0;
  int n_checks = 0;
  always #5 clk_i = ~clk_i;
  tog_top #(.PPS_CYCLES(PPS_N)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .nv_tuning_i(32'h0000_0abc),
    .nv_period_i(32'h0000_0003), .nv_control_i(32'hffff_ffff),
    .pps_i(pps), .major_time_i(major),
    .minor_time_i(minor), .event_i(ev), .event2_i(ev2), .event3_i(ev3),
    .rx_packet_i(rx), .shared_out_o(shared), .strobe_o(strobe),
    .pps_o(ppso), .freq_o(freq), .irq_o(irq));
  tog_sink u_hb (.clk_i(clk_i), .sig_i(shared), .hi_len_o(hb_hi),
    .lo_len_o(hb_lo));
  tog_sink u_fq (.clk_i(clk_i), .sig_i(freq), .hi_len_o(fq_hi), .lo_len_o());
  tog_sink u_pp (.clk_i(clk_i), .sig_i(ppso), .hi_len_o(pp_hi), .lo_len_o());
  tog_sink u_st (.clk_i(clk_i), .sig_i(strobe), .hi_len_o(st_hi), .lo_len_o());
  // ------------------------------------------------------------
  // Shared tasks.
  // ------------------------------------------------------------
  task check_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task results();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] v);
    cyc(1);
    addr = a;
    wdata = v;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, output logic [31:0] v);
    cyc(1);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    v = rdata;
  endtask
  task wr_rd(input logic [7:0] a, input logic [31:0] v, output logic [31:0] r);
    wr_reg(a, v);
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    r = rdata;
  endtask
  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  task t_regs();
    rd_reg(`TOG_OFS_DIVISORS, d);
    `CHK(d, `TOG_RST_DIVISORS);
    rd_reg(`TOG_OFS_CONTROL, d);
    `CHK(d, `TOG_CTL_DDS_MASK);
    rd_reg(`TOG_OFS_TUNING, d);
    `CHK(d, 32'h0000_0abc);
    rd_reg(`TOG_OFS_PERIOD, d);
    `CHK(d, 32'h0000_0003);
    rd_reg(`TOG_OFS_MASK, d);
    `CHK(d, `TOG_RST_MASK);
    rd_reg(8'h20, d);
    `CHK(d, 32'h0);
    wr_rd(`TOG_OFS_MASK, 32'hffff_ffff, d);
    `CHK(d, 32'h7f);
    wr_rd(`TOG_OFS_MASK, 32'h0, d);
    `CHK(d, 32'h0);
    wr_rd(`TOG_OFS_TUNING, 32'h1234_5678, d);
    `CHK(d, 32'h1234_5678);
  endtask
  task t_pps();
    pps = 1'b1;
    cyc(1);
    pps = 1'b0;
    cyc(30);
    `CHK(pp_hi, PPS_N);
    rd_reg(`TOG_OFS_FLAGS, d);
    `CHK(d & 32'h8, 32'h8);
    `CHK(32'(irq), 32'h0);
    wr_reg(`TOG_OFS_MASK, 32'h8);
    cyc(1);
    `CHK(32'(irq), 32'h1);
    wr_reg(`TOG_OFS_FLAGS, 32'h8);
    cyc(1);
    `CHK(32'(irq), 32'h0);
    wr_reg(`TOG_OFS_MASK, 32'h0);
  endtask
  task t_events();
    logic [31:0] bits [4] = '{32'h1, 32'h10, 32'h20, 32'h40};
    for (int i = 0; i < 4; i++) begin
      case (i)
        0: ev = 1'b1;
        1: rx = 1'b1;
        2: ev2 = 1'b1;
        default: ev3 = 1'b1;
      endcase
      cyc(1);
      rx = 1'b0;
      cyc(2);
      rd_reg(`TOG_OFS_FLAGS, d);
      `CHK(d & bits[i], bits[i]);
    end
    wr_reg(`TOG_OFS_FLAGS, 32'h71);
    rd_reg(`TOG_OFS_FLAGS, d);
    `CHK(d & 32'h71, 32'h0);
    ev = 1'b0;
    cyc(3);
    rd_reg(`TOG_OFS_FLAGS, d);
    `CHK(d & 32'h1, 32'h0);
    wr_reg(`TOG_OFS_CONTROL, 32'h1 << `TOG_CTL_EDGE_POL);
    ev = 1'b1;
    cyc(3);
    rd_reg(`TOG_OFS_FLAGS, d);
    `CHK(d & 32'h1, 32'h0);
    ev = 1'b0;
    cyc(3);
    rd_reg(`TOG_OFS_FLAGS, d);
    `CHK(d & 32'h1, 32'h1);
    wr_reg(`TOG_OFS_FLAGS, 32'h1);
    wr_reg(`TOG_OFS_CONTROL, 32'h0);
  endtask
  task t_strobe();
    wr_reg(`TOG_OFS_STB_MINOR, 32'h5);
    wr_reg(`TOG_OFS_STB_MAJOR, 32'h7);
    for (int m = 2; m >= 0; m--) begin
      wr_reg(`TOG_OFS_FLAGS, 32'h4);
      wr_reg(`TOG_OFS_CONTROL, 32'(m == 2) << `TOG_CTL_STB_MODE);
      major = (m == 0) ? 32'h7 : 32'h0;
      minor = 20'h5;
      cyc(150);
      minor = 20'h0;
      rd_reg(`TOG_OFS_FLAGS, d);
      `CHK(d & 32'h4, 32'(m != 1) << 2);
      if (m != 1) `CHK(st_hi, `TOG_STB_CYC);
    end
  endtask
  task t_heartbeat();
    logic [31:0] dv [2] = '{32'h0002_0001, 32'h0fa0_07d0};
    int n;
    wr_reg(`TOG_OFS_FLAGS, 32'h2);
    cyc(1000);
    `CHK(hb_hi, 32'd200);
    `CHK(hb_lo, 32'd200);
    rd_reg(`TOG_OFS_FLAGS, d);
    `CHK(d & 32'h2, 32'h2);
    for (int i = 0; i < 2; i++) begin
      wr_reg(`TOG_OFS_CONTROL, 32'(i));
      wr_reg(`TOG_OFS_DIVISORS, dv[i]);
      cyc(2);
      n = 0;
      repeat (600) begin
        cyc(1);
        if (shared !== 1'b1) n++;
      end
      `CHK(32'(n), 32'h0);
    end
    wr_reg(`TOG_OFS_DIVISORS, `TOG_RST_DIVISORS);
    wr_reg(`TOG_OFS_CONTROL, 32'h0);
  endtask
  task t_freq();
    logic [31:0] half [3] = '{`TOG_F1_HALF, `TOG_F5_HALF, `TOG_F10_HALF};
    for (int i = 0; i < 3; i++) begin
      wr_reg(`TOG_OFS_CONTROL, 32'(i) << `TOG_CTL_FSEL);
      cyc(300);
      `CHK(fq_hi, half[i]);
    end
  endtask
  task t_dds();
    logic [31:0] ctl [5] = '{32'h32, 32'h32, 32'h52, 32'h2, 32'h20a};
    logic [31:0] per [5] = '{32'h0, 32'h3, 32'h0, 32'h0, 32'h0};
    logic [31:0] prd [5] = '{32'd4, 32'd10, 32'd10, 32'd10, 32'd5};
    wr_reg(`TOG_OFS_TUNING, 32'h1312_d000);
    for (int i = 0; i < 5; i++) begin
      wr_reg(`TOG_OFS_PERIOD, per[i]);
      wr_reg(`TOG_OFS_CONTROL, ctl[i]);
      cyc(40);
      `CHK(hb_hi + hb_lo, prd[i]);
      if (i < 4) `CHK(2 * hb_hi, prd[i]);
    end
    wr_reg(`TOG_OFS_FLAGS, 32'h2);
    cyc(4);
    rd_reg(`TOG_OFS_FLAGS, d);
    `CHK(d & 32'h2, 32'h2);
    wr_reg(`TOG_OFS_CONTROL, 32'h0);
  endtask
  // ------------------------------------------------------------
  // Main sequence and watchdog.
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    cyc(2);
    t_regs();
    t_pps();
    t_events();
    t_strobe();
    t_heartbeat();
    t_freq();
    t_dds();
    results();
  end
  initial begin
    #500000;
    fails++;
    results();
  end
endmodule // tog_top_tb_top
`default_nettype wire
